// ---- rtl/tdpr_pkg.sv ----
// Package for the timing and digital line pin routing block.
// Assumes a single 200 MHz clock and the plain register port of the top.
package tdpr_pkg;
	localparam int unsigned NUM_TIMING = 13;
	localparam int unsigned NUM_PINS = 10;
	localparam int unsigned NUM_LINES = 8;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [5:0] OFF_TSEL_BASE = 6'h00;
	localparam logic [5:0] OFF_PROUTE_BASE = 6'h10;
	localparam logic [5:0] OFF_PIN_OE_LO = 6'h1A;
	localparam logic [5:0] OFF_PIN_OE_HI = 6'h1B;
	localparam logic [5:0] OFF_LINE_DIR = 6'h1C;
	localparam logic [5:0] OFF_LINE_OUT = 6'h1D;
	localparam logic [5:0] OFF_LINE_IN = 6'h1E;
	localparam logic [5:0] OFF_PIN_IN_LO = 6'h1F;
	localparam logic [5:0] OFF_PIN_IN_HI = 6'h20;

	// Timing select field layout: [3:0] pin index, [5:4] source kind
	localparam int unsigned TSEL_PIN_LSB = 0;
	localparam int unsigned TSEL_KIND_LSB = 4;
	// Index of the conversion start signal among the timing signals
	localparam int unsigned CONVERT_IDX = 0;

	// Reset values
	localparam logic [5:0] TSEL_RST = 6'h00;
	localparam logic [3:0] PROUTE_RST = 4'h0;
	localparam logic [9:0] PIN_OE_RST = 10'h000;
	localparam logic [7:0] LINE_DIR_RST = 8'h00;
	localparam logic [7:0] LINE_OUT_RST = 8'h00;

	localparam int unsigned LINE_SIX = 6;
	localparam int unsigned LINE_SEVEN = 7;

	typedef enum logic [1:0] {
		TDPR_SRC_PIN,
		TDPR_SRC_INTERNAL,
		TDPR_SRC_SAMPLE_TC,
		TDPR_SRC_COUNTER0
	} tdpr_src_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tdpr_req_t;

	typedef struct packed {
		tdpr_src_t kind;
		logic [3:0] pin;
	} tdpr_tsel_t;
endpackage

// ---- rtl/tdpr_top.sv ----
// Timing signal selection, function pin drivers and general digital lines.
// Assumes pins arrive asynchronously; internal sources share mclk.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Each of thirteen timing signals takes a software chosen source.
// (R2) Every timing selector can pick any of the ten function pins.
// (R3) Several timing signals may pick the same pin with no conflict.
// (R4) A function pin drives only when enabled, then shows one timing signal.
// (R5) Conversion start may come from a pin, sample terminal count or counter0.
// (R6) Eight general digital lines each have a software set direction.
// (R7) After reset all eight general digital lines are undriven.
// (R8) Lines six and seven feed counter directions without affecting them.
// (R9) After reset no function pin output is enabled.
module tdpr_top (
	input wire logic mclk,
	input wire logic nrst,
	input tdpr_pkg::tdpr_req_t req,
	output logic [tdpr_pkg::DATA_W-1:0] rdata,
	input wire logic [tdpr_pkg::NUM_TIMING-1:0] internal_timing_src,
	input wire logic sample_interval_terminal_count,
	input wire logic counter0_output,
	output logic [tdpr_pkg::NUM_TIMING-1:0] timing_signal,
	input wire logic [tdpr_pkg::NUM_PINS-1:0] programmable_function_pin_in,
	output logic [tdpr_pkg::NUM_PINS-1:0] programmable_function_pin_out,
	output logic [tdpr_pkg::NUM_PINS-1:0] programmable_function_pin_oe,
	input wire logic [tdpr_pkg::NUM_LINES-1:0] general_digital_line_in,
	output logic [tdpr_pkg::NUM_LINES-1:0] general_digital_line_out,
	output logic [tdpr_pkg::NUM_LINES-1:0] general_digital_line_oe,
	output logic counter0_count_direction,
	output logic counter1_count_direction
);
	localparam int unsigned NT = tdpr_pkg::NUM_TIMING;
	localparam int unsigned NP = tdpr_pkg::NUM_PINS;
	localparam int unsigned NL = tdpr_pkg::NUM_LINES;

	function automatic logic [5:0] sel_to_bits(input tdpr_pkg::tdpr_tsel_t s);
		sel_to_bits = {s.kind, s.pin};
	endfunction

	// One write decode shared by every configuration field
	function automatic logic wr_hit(input tdpr_pkg::tdpr_req_t r,
		input logic [5:0] off);
		wr_hit = r.wr && (r.addr == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// Left without reset; they flush on their own within two edges
	logic [NP-1:0] pin_meta_q, pin_meta_d, pin_sync_q, pin_sync_d;
	logic [NL-1:0] line_meta_q, line_meta_d, line_sync_q, line_sync_d;

	always_comb begin
		pin_meta_d = programmable_function_pin_in;
		pin_sync_d = pin_meta_q;
		line_meta_d = general_digital_line_in;
		line_sync_d = line_meta_q;
	end

	always_ff @(posedge mclk) begin
		pin_meta_q <= pin_meta_d;
		pin_sync_q <= pin_sync_d;
		line_meta_q <= line_meta_d;
		line_sync_q <= line_sync_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	// Reset leaves every selector on pin 0 and every driver off
	tdpr_pkg::tdpr_tsel_t tsel_q [NT];
	tdpr_pkg::tdpr_tsel_t tsel_d [NT];
	logic [3:0] proute_q [NP];
	logic [3:0] proute_d [NP];
	logic [NP-1:0] pin_oe_cfg_q, pin_oe_cfg_d;
	logic [NL-1:0] line_dir_q, line_dir_d;
	logic [NL-1:0] line_out_q, line_out_d;
	logic [tdpr_pkg::DATA_W-1:0] rdata_d;

	always_comb begin
		logic [5:0] a;
		a = req.addr;
		for (int i = 0; i < NT; i++) begin
			tsel_d[i] = tsel_q[i];
			if (wr_hit(req, tdpr_pkg::OFF_TSEL_BASE + 6'(i))) begin
				tsel_d[i].pin = req.wdata[tdpr_pkg::TSEL_PIN_LSB +: 4];
				tsel_d[i].kind = tdpr_pkg::tdpr_src_t'(
					req.wdata[tdpr_pkg::TSEL_KIND_LSB +: 2]);
			end
		end
		for (int p = 0; p < NP; p++) begin
			proute_d[p] = proute_q[p];
			if (wr_hit(req, tdpr_pkg::OFF_PROUTE_BASE + 6'(p))) begin
				proute_d[p] = req.wdata[3:0];
			end
		end
		// Pin enables span two offsets; the upper one holds bits 9:8 only
		pin_oe_cfg_d = pin_oe_cfg_q;
		if (wr_hit(req, tdpr_pkg::OFF_PIN_OE_LO)) begin
			pin_oe_cfg_d[7:0] = req.wdata;
		end
		if (wr_hit(req, tdpr_pkg::OFF_PIN_OE_HI)) begin
			pin_oe_cfg_d[NP-1:8] = req.wdata[NP-9:0];
		end
		// Writes to read-only or unmapped offsets fall through untouched
		line_dir_d = line_dir_q;
		if (wr_hit(req, tdpr_pkg::OFF_LINE_DIR)) begin
			line_dir_d = req.wdata; // see (R6)
		end
		line_out_d = line_out_q;
		if (wr_hit(req, tdpr_pkg::OFF_LINE_OUT)) begin
			line_out_d = req.wdata;
		end

		// Read data stands in the cycle after the strobe only
		// Narrow fields read back with their upper bits clear
		rdata_d = '0;
		if (req.rd) begin
			for (int i = 0; i < NT; i++) begin
				if (a == tdpr_pkg::OFF_TSEL_BASE + 6'(i)) begin
					rdata_d = {2'h0, sel_to_bits(tsel_q[i])};
				end
			end
			for (int p = 0; p < NP; p++) begin
				if (a == tdpr_pkg::OFF_PROUTE_BASE + 6'(p)) begin
					rdata_d = {4'h0, proute_q[p]};
				end
			end
			case (a)
				tdpr_pkg::OFF_PIN_OE_LO: rdata_d = pin_oe_cfg_q[7:0];
				tdpr_pkg::OFF_PIN_OE_HI: rdata_d = {6'h00, pin_oe_cfg_q[NP-1:8]};
				tdpr_pkg::OFF_LINE_DIR: rdata_d = line_dir_q;
				tdpr_pkg::OFF_LINE_OUT: rdata_d = line_out_q;
				tdpr_pkg::OFF_LINE_IN: rdata_d = line_sync_q;
				tdpr_pkg::OFF_PIN_IN_LO: rdata_d = pin_sync_q[7:0];
				tdpr_pkg::OFF_PIN_IN_HI: rdata_d = {6'h00, pin_sync_q[NP-1:8]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			for (int i = 0; i < NT; i++) begin
				tsel_q[i] <= tdpr_pkg::tdpr_tsel_t'(tdpr_pkg::TSEL_RST);
			end
			for (int p = 0; p < NP; p++) begin
				proute_q[p] <= tdpr_pkg::PROUTE_RST;
			end
			pin_oe_cfg_q <= tdpr_pkg::PIN_OE_RST; // see (R9)
			line_dir_q <= tdpr_pkg::LINE_DIR_RST; // see (R7)
			line_out_q <= tdpr_pkg::LINE_OUT_RST;
			rdata <= '0;
		end else begin
			tsel_q <= tsel_d;
			proute_q <= proute_d;
			pin_oe_cfg_q <= pin_oe_cfg_d;
			line_dir_q <= line_dir_d;
			line_out_q <= line_out_d;
			rdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Routing datapath, registered so every output leaves a flip-flop
	// Pin sourced timing signals therefore lag their pad by three edges
	logic [NT-1:0] timing_d;
	logic [NP-1:0] pin_out_d, pin_oe_d;
	logic [NL-1:0] line_out_pin_d, line_oe_d;
	logic dir0_d, dir1_d;

	always_comb begin
		for (int i = 0; i < NT; i++) begin
			// Each selector reads the shared pin vector, so no pin is owned
			case (tsel_q[i].kind) // see (R1)
				tdpr_pkg::TDPR_SRC_PIN: begin
					// Indices past the last pin read low
					timing_d[i] = (tsel_q[i].pin < 4'(NP)) ?
						pin_sync_q[tsel_q[i].pin] : 1'b0; // see (R2) (R3)
				end
				tdpr_pkg::TDPR_SRC_INTERNAL: timing_d[i] = internal_timing_src[i];
				tdpr_pkg::TDPR_SRC_SAMPLE_TC: begin
					timing_d[i] = sample_interval_terminal_count; // see (R5)
				end
				tdpr_pkg::TDPR_SRC_COUNTER0: timing_d[i] = counter0_output; // see (R5)
				default: timing_d[i] = 1'b0;
			endcase
		end
		for (int p = 0; p < NP; p++) begin
			// Driven pins show the chosen internal signal, not the looped pin
			// Route codes past the last signal drive low, never unknown
			pin_out_d[p] = (proute_q[p] < 4'(NT)) ?
				internal_timing_src[proute_q[p]] : 1'b0; // see (R4)
			pin_oe_d[p] = pin_oe_cfg_q[p]; // see (R4)
		end
		line_out_pin_d = line_out_q;
		line_oe_d = line_dir_q; // see (R6)
		// Taps read the synchronised pad only and never touch the drivers
		dir0_d = line_sync_q[tdpr_pkg::LINE_SIX]; // see (R8)
		dir1_d = line_sync_q[tdpr_pkg::LINE_SEVEN]; // see (R8)
	end

	// Drivers come up off, so nothing fights the connector after reset
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			timing_signal <= '0;
			programmable_function_pin_out <= '0;
			programmable_function_pin_oe <= '0; // see (R9)
			general_digital_line_out <= '0;
			general_digital_line_oe <= '0; // see (R7)
			counter0_count_direction <= 1'b0;
			counter1_count_direction <= 1'b0;
		end else begin
			timing_signal <= timing_d;
			programmable_function_pin_out <= pin_out_d;
			programmable_function_pin_oe <= pin_oe_d;
			general_digital_line_out <= line_out_pin_d;
			general_digital_line_oe <= line_oe_d;
			counter0_count_direction <= dir0_d;
			counter1_count_direction <= dir1_d;
		end
	end
endmodule

// ---- sim/tdpr_assertions.sv ----
// Checker for the pin routing top, watching its ports only.
// Assumes the single mclk domain with synchronous active low nrst.
`timescale 1ns/1ps
module tdpr_assertions (
	input wire logic mclk,
	input wire logic nrst,
	input tdpr_pkg::tdpr_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [9:0] programmable_function_pin_oe,
	input wire logic [7:0] general_digital_line_in,
	input wire logic [7:0] general_digital_line_oe,
	input wire logic counter0_count_direction,
	input wire logic counter1_count_direction
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	property p_line_rst; !$past(nrst) |-> general_digital_line_oe == 8'h00;
	endproperty
	a_line_rst: assert property (p_line_rst)
		else $error("line driven after reset");
	property p_pin_rst;
		!$past(nrst) |-> programmable_function_pin_oe == 10'h000;
	endproperty
	a_pin_rst: assert property (p_pin_rst)
		else $error("pin driven after reset");
	property p_pin_lo; req.wr && req.addr == tdpr_pkg::OFF_PIN_OE_LO |->
		##2 programmable_function_pin_oe[7:0] == $past(req.wdata, 2);
	endproperty
	a_pin_lo: assert property (p_pin_lo)
		else $error("low pin enables wrong");
	property p_pin_hi; req.wr && req.addr == tdpr_pkg::OFF_PIN_OE_HI |->
		##2 programmable_function_pin_oe[9:8] == $past(req.wdata[1:0], 2);
	endproperty
	a_pin_hi: assert property (p_pin_hi)
		else $error("high pin enables wrong");
	property p_dir; req.wr && req.addr == tdpr_pkg::OFF_LINE_DIR |->
		##2 general_digital_line_oe == $past(req.wdata, 2);
	endproperty
	a_dir: assert property (p_dir)
		else $error("line direction wrong");
	// Taps lag the pad by the two synchroniser stages plus one register
	property p_tap0; nrst[*4] |->
		counter0_count_direction == $past(general_digital_line_in[6], 3);
	endproperty
	a_tap0: assert property (p_tap0)
		else $error("counter0 direction wrong");
	property p_tap1; nrst[*4] |->
		counter1_count_direction == $past(general_digital_line_in[7], 3);
	endproperty
	a_tap1: assert property (p_tap1)
		else $error("counter1 direction wrong");
	property p_rd_idle; !$past(req.rd) |-> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
endmodule
bind tdpr_top tdpr_assertions u_chk (.mclk, .nrst, .req, .rdata,
	.programmable_function_pin_oe, .general_digital_line_in,
	.general_digital_line_oe, .counter0_count_direction,
	.counter1_count_direction);

// ---- sim/tdpr_partner.sv ----
// Connector side: instruments drive every pin the device leaves off.
// Assumes enables high mean the device drives.
`timescale 1ns/1ps
module tdpr_partner (
	input wire logic [9:0] pin_out,
	input wire logic [9:0] pin_oe,
	input wire logic [9:0] pin_ext,
	output logic [9:0] pin_wire,
	input wire logic [7:0] line_out,
	input wire logic [7:0] line_oe,
	input wire logic [7:0] line_ext,
	output logic [7:0] line_wire
);
	// Outside source yields wherever the device drives, so no contention
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_ext);
	assign line_wire = (line_oe & line_out) | (~line_oe & line_ext);
endmodule

// ---- sim/timing_and_dio_pin_routing_test.sv ----
// Self-checking bench for the pin routing top.
// Assumes the partner resolves pad levels; reads answer one cycle later.
`timescale 1ns/1ps
module timing_and_dio_pin_routing_test;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic tc = 1'b1;
	logic c0 = 1'b0;
	logic cd0, cd1;
	tdpr_pkg::tdpr_req_t req = '0;
	logic [7:0] rdata, lout, loe, lw;
	logic [7:0] lext = 8'hC0;
	logic [9:0] pout, poe, pw;
	logic [9:0] pext = 10'h2A5;
	logic [12:0] ts;
	logic [12:0] src = 13'h1555;
	logic [12:0] ex_v = 13'h0EA7;
	logic [5:0] sel_tab [13] = '{6'h00, 6'h00, 6'h02, 6'h03, 6'h04, 6'h05,
		6'h06, 6'h07, 6'h08, 6'h09, 6'h10, 6'h20, 6'h30};
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////////
	tdpr_top dut (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata),
		.internal_timing_src(src), .sample_interval_terminal_count(tc),
		.counter0_output(c0), .timing_signal(ts),
		.programmable_function_pin_in(pw), .programmable_function_pin_out(pout),
		.programmable_function_pin_oe(poe), .general_digital_line_in(lw),
		.general_digital_line_out(lout), .general_digital_line_oe(loe),
		.counter0_count_direction(cd0), .counter1_count_direction(cd1));
	tdpr_partner u_far (.pin_out(pout), .pin_oe(poe), .pin_ext(pext),
		.pin_wire(pw), .line_out(lout), .line_oe(loe), .line_ext(lext),
		.line_wire(lw));
	initial forever #2.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge mclk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		req <= '0;
		#1;
		chk(16'(rdata), 16'(e));
	endtask
	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		wt(1);
		chk(16'(poe), 16'h0000);
		chk(16'(loe), 16'h0000);
		for (int i = 0; i < 13; i++) begin
			wr(6'(i), {2'b00, sel_tab[i]});
			wt(4);
			chk(16'(ts[i]), 16'(ex_v[i]));
		end
		@(posedge mclk);
		pext <= ~pext;
		src <= ~src;
		tc <= 1'b0;
		c0 <= 1'b1;
		wt(4);
		chk(16'(ts ^ ex_v), 16'h1FFF);
		@(posedge mclk);
		tc <= 1'b1;
		c0 <= 1'b0;
		wr(6'h00, 8'h20);
		wt(4);
		chk(16'(ts[0]), 16'h0001);
		@(posedge mclk);
		tc <= 1'b0;
		c0 <= 1'b1;
		wr(6'h00, 8'h30);
		wt(4);
		chk(16'(ts[0]), 16'h0001);
		wr(6'h15, 8'h03);
		wr(6'h1A, 8'h20);
		wr(6'h1B, 8'h02);
		wt(4);
		chk(16'(poe), 16'h0220);
		chk(16'({pout[9], pout[5]}), 16'({src[0], src[3]}));
		// Driven pins loop back: pin 5 shows its route, pin 9 drives low
		rd(6'h1F, 8'h7A);
		rd(6'h20, 8'h01);
		wr(6'h03, 8'h0C);
		wt(4);
		chk(16'(ts[3]), 16'h0000);
		rd(6'h0C, 8'h30);
		wr(6'h15, 8'h0F);
		wt(4);
		chk(16'(pout[5]), 16'h0000);
		wr(6'h1C, 8'h0F);
		wr(6'h1D, 8'h05);
		wt(4);
		chk(16'({loe, lout[3:0]}), 16'h00F5);
		rd(6'h1E, 8'hC5);
		chk(16'({cd1, cd0}), 16'h0003);
		@(posedge mclk);
		lext <= 8'h40;
		wt(4);
		chk(16'({cd1, cd0}), 16'h0001);
		rd(6'h3F, 8'h00);
		@(posedge mclk);
		nrst <= 1'b0;
		wt(3);
		@(posedge mclk);
		nrst <= 1'b1;
		wt(1);
		chk(16'(poe), 16'h0000);
		chk(16'(loe), 16'h0000);
		rd(6'h1C, 8'h00);
		close_out();
	end
endmodule
